// *** include/lps_params.svh ***
// Constants for the LED driver power sequencer
`ifndef LPS_PARAMS_SVH
`define LPS_PARAMS_SVH
`define LPS_BR_W 5
`define LPS_BR_MAX 5'h1F
`define LPS_BR_ZERO 5'h00
`define LPS_SS_W 8
`define LPS_SS_STEPS 8'hFF
`define LPS_HYST_W 4
`define LPS_HYST_CNT 4'hF
`endif

// *** include/lps_pkg.sv ***
// Types for the LED driver power sequencer
package lps_pkg;
  typedef enum logic [1:0] {
    LPS_MODE_1X,
    LPS_MODE_3_2,
    LPS_MODE_2_1
  } lps_mode_t;
  typedef enum logic [1:0] {
    LPS_ST_LOWPWR,
    LPS_ST_SOFTSTART,
    LPS_ST_RUN,
    LPS_ST_THERMAL
  } lps_state_t;
endpackage : lps_pkg

// *** core/lps_sync.sv ***
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module lps_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Data
  input wire logic async_in,
  output logic sync_out
);
  logic meta_ff;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= 1'b0;
      sync_out <= 1'b0;
    end else if (clk_en) begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule : lps_sync

// *** core/lps_sequencer.sv ***
// Power-state, soft-start and pump mode sequencer for a three-channel LED driver
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
`timescale 1ns/1ps
`include "lps_params.svh"
module lps_sequencer (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Host pins and decoded command
  input wire logic chip_on_pin,
  input wire logic cmd_valid,
  input wire logic [`LPS_BR_W-1:0] cmd_word,
  // Analogue status
  input wire logic over_temp,
  input wire logic headroom_low,
  input wire logic headroom_high,
  // Outputs
  output logic power_on_request,
  output logic shutdown,
  output logic [`LPS_BR_W-1:0] brightness_word,
  output logic [`LPS_SS_W-1:0] soft_start_level,
  output lps_pkg::lps_mode_t pump_mode
);
  import lps_pkg::*;

  // ---------------------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------------------
  // Word rides the same two flops as valid; the host must set it no later than valid
  localparam int NSYNC = `LPS_BR_W + 5;
  logic chip_on_s, cmd_valid_s, over_temp_s, low_s, high_s;
  logic [`LPS_BR_W-1:0] word_s;
  logic chip_on_d_ff, cmd_valid_d_ff;
  logic [NSYNC-1:0] async_in, sync_out;
  assign async_in = {cmd_word, chip_on_pin, cmd_valid, over_temp, headroom_low, headroom_high};
  assign {word_s, chip_on_s, cmd_valid_s, over_temp_s, low_s, high_s} = sync_out;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      lps_sync u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .async_in(async_in[gi]),
        .sync_out(sync_out[gi])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      chip_on_d_ff <= 1'b0;
      cmd_valid_d_ff <= 1'b0;
    end else if (clk_en) begin
      chip_on_d_ff <= chip_on_s;
      cmd_valid_d_ff <= cmd_valid_s;
    end
  end

  logic on_rise, on_fall, cmd_stb, cmd_nz, cmd_z;
  assign on_rise = chip_on_s & ~chip_on_d_ff;
  assign on_fall = ~chip_on_s & chip_on_d_ff;
  // Command word is stable while valid is high, so it is read at the valid edge
  assign cmd_stb = cmd_valid_s & ~cmd_valid_d_ff;
  assign cmd_nz = cmd_stb && (word_s != `LPS_BR_ZERO);
  assign cmd_z = cmd_stb && (word_s == `LPS_BR_ZERO);

  // ---------------------------------------------------------------------------
  // Brightness word
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      brightness_word <= `LPS_BR_MAX;
    end else if (clk_en && cmd_stb) begin
      brightness_word <= word_s;
    end
  end

  // ---------------------------------------------------------------------------
  // Power-on request
  // ---------------------------------------------------------------------------
  // Request resets low; synchronisers reset low too, so a pin high at power-up reads as a rise
  logic nxt_req;
  logic req_ff;
  always_comb begin
    nxt_req = req_ff;
    if (cmd_z || on_fall) begin
      nxt_req = 1'b0;
    end
    if (cmd_nz || on_rise) begin
      nxt_req = 1'b1;
    end
    if (cmd_z) begin
      nxt_req = 1'b0;
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      req_ff <= 1'b0;
    end else if (clk_en) begin
      req_ff <= nxt_req;
    end
  end

  // ---------------------------------------------------------------------------
  // Power state machine
  // ---------------------------------------------------------------------------
  lps_state_t state_ff, nxt_state;
  logic [`LPS_SS_W-1:0] ss_ff;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      LPS_ST_LOWPWR: begin
        if (req_ff) begin
          nxt_state = LPS_ST_SOFTSTART;
        end
      end
      LPS_ST_SOFTSTART: begin
        if (!req_ff) begin
          nxt_state = LPS_ST_LOWPWR;
        end else if (ss_ff == `LPS_SS_STEPS) begin
          nxt_state = LPS_ST_RUN;
        end
      end
      LPS_ST_RUN: begin
        if (!req_ff) begin
          nxt_state = LPS_ST_LOWPWR;
        end
      end
      default: begin
        if (!over_temp_s) begin
          nxt_state = LPS_ST_LOWPWR;
        end
      end
    endcase
    if (over_temp_s) begin
      nxt_state = LPS_ST_THERMAL;
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= LPS_ST_LOWPWR;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------------------
  // Soft-start ramp
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ss_ff <= '0;
    end else if (clk_en) begin
      if (nxt_state == LPS_ST_LOWPWR || nxt_state == LPS_ST_THERMAL) begin
        ss_ff <= '0;
      end else if (ss_ff != `LPS_SS_STEPS) begin
        ss_ff <= ss_ff + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Pump mode with hysteresis
  // ---------------------------------------------------------------------------
  // Headroom must persist a full count before a step; limits chatter near thresholds
  logic [`LPS_HYST_W-1:0] hyst_ff;
  lps_mode_t mode_ff;
  logic run_ok;
  assign run_ok = (state_ff == LPS_ST_RUN);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hyst_ff <= '0;
      mode_ff <= LPS_MODE_1X;
    end else if (clk_en) begin
      if (!run_ok) begin
        hyst_ff <= '0;
        mode_ff <= LPS_MODE_1X;
      end else if (low_s == high_s) begin
        hyst_ff <= '0;
      end else if (hyst_ff != `LPS_HYST_CNT) begin
        hyst_ff <= hyst_ff + 1'b1;
      end else begin
        hyst_ff <= '0;
        if (low_s && mode_ff == LPS_MODE_1X) begin
          mode_ff <= LPS_MODE_3_2;
        end else if (low_s && mode_ff == LPS_MODE_3_2) begin
          mode_ff <= LPS_MODE_2_1;
        end else if (high_s && mode_ff == LPS_MODE_2_1) begin
          mode_ff <= LPS_MODE_3_2;
        end else if (high_s && mode_ff == LPS_MODE_3_2) begin
          mode_ff <= LPS_MODE_1X;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      power_on_request <= 1'b0;
      shutdown <= 1'b1;
      soft_start_level <= '0;
      pump_mode <= LPS_MODE_1X;
    end else if (clk_en) begin
      power_on_request <= req_ff && (state_ff != LPS_ST_THERMAL);
      shutdown <= !req_ff || (state_ff == LPS_ST_THERMAL);
      soft_start_level <= ss_ff;
      pump_mode <= mode_ff;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_rise_seen;
    clk_en && on_rise && !cmd_z && !over_temp_s;
  endsequence
  chk_rise_sets_req: assert property (s_rise_seen |=> req_ff) else $error("rise did not set request");
  chk_zero_clears_req: assert property (clk_en && cmd_z |=> !req_ff) else $error("zero command kept request");
  chk_fall_clears_req: assert property (clk_en && on_fall && !cmd_nz |=> !req_ff) else $error("fall kept request");
  chk_cmd_loads_word: assert property (clk_en && cmd_stb |=> brightness_word == $past(word_s))
    else $error("word not loaded");
  chk_req_out_follows: assert property (clk_en && req_ff && state_ff != LPS_ST_THERMAL |=> power_on_request)
    else $error("request output lags");
  chk_shutdown_idle: assert property (clk_en && !req_ff |=> shutdown) else $error("no shutdown when off");
  chk_hot_enters: assert property (clk_en && over_temp_s |=> state_ff == LPS_ST_THERMAL)
    else $error("thermal not entered");
  chk_hot_holds: assert property (clk_en && state_ff == LPS_ST_THERMAL |=> !power_on_request)
    else $error("thermal not held");
  chk_ramp_starts: assert property (clk_en && state_ff == LPS_ST_LOWPWR && req_ff && !over_temp_s
    |=> state_ff == LPS_ST_SOFTSTART && ss_ff == 8'h01) else $error("soft-start not begun");
  // Leaving run drops straight to 1x by design; only steps taken while running are checked
  chk_mode_adjacent: assert property (run_ok && mode_ff == LPS_MODE_2_1 |=> mode_ff != LPS_MODE_1X)
    else $error("mode skipped a step");
endmodule : lps_sequencer

// *** bench/lps_host_model.sv ***
// Host microcontroller model driving the chip-on and command lines
`timescale 1ns/1ps
`include "lps_params.svh"
module lps_host_model (
  // Clock
  input wire logic ref_clk,
  // Host pins
  output logic chip_on_pin,
  output logic cmd_valid,
  output logic [`LPS_BR_W-1:0] cmd_word
);
  initial begin
    chip_on_pin = 1'b0;
    cmd_valid = 1'b0;
    cmd_word = 5'h00;
  end
  task automatic set_pin(input logic v);
    @(posedge ref_clk) #1 chip_on_pin = v;
  endtask : set_pin
  // Word whole and steady while valid; inverted once released so stale data never looks good
  task automatic send_cmd(input logic [`LPS_BR_W-1:0] w);
    @(posedge ref_clk) #1 cmd_word = w;
    cmd_valid = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 cmd_valid = 1'b0;
    cmd_word = ~w;
    repeat (3) @(posedge ref_clk);
  endtask : send_cmd
endmodule : lps_host_model

// *** bench/tb_lps_sequencer.sv ***
// Self-checking bench for the LED driver power sequencer
`timescale 1ns/1ps
`include "lps_params.svh"
module tb_lps_sequencer;
  import lps_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn;
  logic clk_en;
  logic over_temp;
  logic headroom_low;
  logic headroom_high;
  logic chip_on_pin, cmd_valid, power_on_request, shutdown;
  logic last_req = 1'b0;
  logic [`LPS_BR_W-1:0] cmd_word, brightness_word, w;
  logic [`LPS_SS_W-1:0] soft_start_level, ss_hold;
  lps_mode_t pump_mode;
  logic notes[$];
  logic [7:0] exp_mode[5] = '{8'h00, 8'h01, 8'h02, 8'h01, 8'h00};
  int n_fail = 0;
  int n_compared = 0;
  int seed = 36001;
  always #2.5 ref_clk = ~ref_clk;
  lps_host_model host (.ref_clk(ref_clk), .chip_on_pin(chip_on_pin), .cmd_valid(cmd_valid), .cmd_word(cmd_word));
  lps_sequencer dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .chip_on_pin(chip_on_pin),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .over_temp(over_temp), .headroom_low(headroom_low),
    .headroom_high(headroom_high), .power_on_request(power_on_request), .shutdown(shutdown),
    .brightness_word(brightness_word), .soft_start_level(soft_start_level), .pump_mode(pump_mode));
  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic tally_and_finish();
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic bad(input string msg);
    n_fail++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask : bad
  task automatic cmp_req(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) bad("power-on request edge not expected");
  endtask : cmp_req
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) bad(what);
  endtask : cmp_val
  // Any request change must match the oldest note; a change with no note is a fault
  always @(negedge ref_clk) begin
    if (!rstn) begin
      last_req = 1'b0;
    end else if (power_on_request !== last_req) begin
      last_req = power_on_request;
      cmp_req(power_on_request, notes.size() > 0 ? notes.pop_front() : ~power_on_request);
    end
  end
  task automatic drain();
    for (int i = 0; i < 20 && notes.size() != 0; i++) @(posedge ref_clk);
    if (notes.size() != 0) begin
      bad("request change timed out");
      tally_and_finish();
    end
  endtask : drain
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    over_temp = 1'b0;
    headroom_low = 1'b0;
    headroom_high = 1'b0;
    repeat (16) @(posedge ref_clk);
    #1 rstn = 1'b1;
    @(posedge ref_clk) #1;
    cmp_val(8'(brightness_word), 8'h1F, "brightness after reset");
    cmp_val(8'(shutdown), 8'h01, "shutdown after reset");
    repeat (10) @(posedge ref_clk);
    notes.push_back(1'b1);
    host.set_pin(1'b1);
    repeat (3) @(posedge ref_clk);
    #1;
    cmp_val(8'(power_on_request), 8'h00, "request before synchroniser delay");
    drain();
    cmp_val(8'(shutdown), 8'h00, "shutdown while on");
    // Freeze for a random stretch mid-ramp; nothing may move while enable is low
    repeat (20) @(posedge ref_clk);
    #1 clk_en = 1'b0;
    ss_hold = soft_start_level;
    repeat (2 + ($random(seed) & 7)) @(posedge ref_clk);
    #1;
    cmp_val(soft_start_level, ss_hold, "ramp moved while frozen");
    clk_en = 1'b1;
    for (int i = 0; i < 300 && soft_start_level !== 8'hFF; i++) @(posedge ref_clk);
    cmp_val(soft_start_level, 8'hFF, "soft-start ramp end");
    if (soft_start_level !== 8'hFF) tally_and_finish();
    // Short sag must not move the mode; long ones step once each
    for (int k = 0; k < 5; k++) begin
      @(posedge ref_clk) #1 {headroom_high, headroom_low} = (k < 3) ? 2'b01 : 2'b10;
      repeat (k == 0 ? 8 : 20) @(posedge ref_clk);
      #1 {headroom_high, headroom_low} = 2'b00;
      repeat (4) @(posedge ref_clk);
      cmp_val(8'(pump_mode), exp_mode[k], "pump mode");
    end
    notes.push_back(1'b0);
    host.set_pin(1'b0);
    drain();
    w = 5'($random(seed));
    if (w == 5'h00) w = 5'h01;
    notes.push_back(1'b1);
    host.send_cmd(w);
    drain();
    cmp_val(8'(brightness_word), 8'(w), "brightness from command");
    notes.push_back(1'b0);
    host.send_cmd(5'h00);
    drain();
    cmp_val(8'(brightness_word), 8'h00, "zero brightness");
    cmp_val(8'(shutdown), 8'h01, "shutdown when fully disabled");
    notes.push_back(1'b1);
    host.set_pin(1'b1);
    drain();
    notes.push_back(1'b0);
    @(posedge ref_clk) #1 over_temp = 1'b1;
    drain();
    notes.push_back(1'b1);
    @(posedge ref_clk) #1 over_temp = 1'b0;
    drain();
    // Second power application with chip-on low: only a nonzero command may wake it
    notes.push_back(1'b0);
    host.set_pin(1'b0);
    drain();
    @(posedge ref_clk) #1 rstn = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 rstn = 1'b1;
    @(posedge ref_clk) #1;
    cmp_val(8'(brightness_word), 8'h1F, "brightness after second reset");
    cmp_val(8'(pump_mode), 8'h00, "mode after second reset");
    repeat (10) @(posedge ref_clk);
    cmp_val(8'(shutdown), 8'h01, "low power with chip-on low");
    notes.push_back(1'b1);
    host.send_cmd(w);
    drain();
    cmp_val(8'(brightness_word), 8'(w), "brightness after wake command");
    tally_and_finish();
  end
endmodule : tb_lps_sequencer
